// ---- tzpc_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - prescaler private to this counter, not watchdog
// - bypass clear puts prescaler in path
// - select picks divide 2 to 256
// - bypass set counts every event, 1:1
// - prescaler count never software visible
// - count write clears the prescaler
// - FFh to 00h rollover is overflow event
// - flag sets on overflow regardless of enable
// - only software clears the flag
// - interrupt only while enable bit set
// - external edge synchronised to instruction clock
// - prescaler output sampled on Q2, Q4 in counter mode
// - no counting while asleep
// - count holds its value during sleep
// - overflow cannot wake from sleep
module tzpc_top (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input tzpc_pkg::tzpc_bus_t bus_req,
    output logic [7:0] rdata,
    // external count pin and processor sleep state
    input wire logic external_count_input,
    input wire logic sleep,
    // interrupt request
    output logic irq
);

    tzpc_pkg::tzpc_phase_t phase_reg;  // current quarter phase
    tzpc_pkg::tzpc_phase_t phase_next;
    tzpc_pkg::tzpc_cfg_t cfg_reg;      // counting configuration
    logic [7:0] count_reg;             // timer_zero_count
    logic [7:0] presc_reg;             // private prescaler count
    logic tap_prev_reg;                // last prescaler tap, timer mode
    logic samp_reg;                    // Q2/Q4 sample of count source
    logic samp_prev_reg;               // previous sample
    logic lvl_prev_reg;                // previous pin level after edge polarity
    logic flag_reg;                    // overflow_flag
    logic en_reg;                      // overflow_irq_enable
    logic pin_level;                   // synchronised pin
    logic ext_level;                   // pin after edge polarity
    logic src_evt;                     // one event into the prescaler
    logic tap;                         // selected prescaler bit
    logic cnt_src;                     // level sampled in counter mode
    logic inc;                         // advance timer_zero_count
    logic cnt_wr;                      // software writes the count
    logic ic_wr;                       // software writes interrupt_control
    logic cfg_wr;                      // software writes configuration
    logic ovf;                         // rollover this cycle
    logic [7:0] rd_mux;                // read data before its register

    // rising edge of a level between two cycles
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur && !prev;
    endfunction

    // pin synchroniser to the instruction clock
    tzpc_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(external_count_input),
        .level(pin_level)
    );

    // write decode
    assign cnt_wr = bus_req.wr && (bus_req.addr == tzpc_pkg::ADDR_COUNT);
    assign cfg_wr = bus_req.wr && (bus_req.addr == tzpc_pkg::ADDR_CONFIG);
    assign ic_wr = bus_req.wr && (bus_req.addr == tzpc_pkg::ADDR_INTCTL);

    // quarter-phase sequencer
    always_comb begin
        case (phase_reg)
            tzpc_pkg::PH_Q1: phase_next = tzpc_pkg::PH_Q2;
            tzpc_pkg::PH_Q2: phase_next = tzpc_pkg::PH_Q3;
            tzpc_pkg::PH_Q3: phase_next = tzpc_pkg::PH_Q4;
            tzpc_pkg::PH_Q4: phase_next = tzpc_pkg::PH_Q1;
            default: phase_next = tzpc_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase_reg <= tzpc_pkg::PH_Q1;
        end else if (ce) begin
            phase_reg <= phase_next;
        end
    end

    // event source: instruction cycle or chosen pin edge
    assign ext_level = pin_level ^ cfg_reg.edge_fall;
    always_comb begin
        if (cfg_reg.src_ext) begin
            src_evt = rise(lvl_prev_reg, ext_level);
        end else begin
            src_evt = (phase_reg == tzpc_pkg::PH_Q4);
        end
    end

    // previous pin level after edge polarity, for edge finding
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lvl_prev_reg <= tzpc_pkg::EDGE_RST;  // idle pin after polarity, so no false edge after reset
        end else if (ce) begin
            lvl_prev_reg <= ext_level;
        end
    end

    // private prescaler, no watchdog connection and no bus access
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            presc_reg <= tzpc_pkg::PRESC_RST;
        end else if (ce) begin
            if (cnt_wr) begin
                presc_reg <= tzpc_pkg::PRESC_RST;
            end else if (src_evt && !sleep) begin
                presc_reg <= presc_reg + tzpc_pkg::PRESC_ONE;
            end
        end
    end

    // tap bit ps toggles once per 2^ps events
    assign tap = presc_reg[cfg_reg.ps];

    // count source level for counter mode
    assign cnt_src = cfg_reg.bypass ? ext_level : tap;

    // sample the count source on Q2 and Q4 only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            samp_reg <= tzpc_pkg::EDGE_RST;       // idle count source, no false step after reset
            samp_prev_reg <= tzpc_pkg::EDGE_RST;
            tap_prev_reg <= 1'b0;
        end else if (ce) begin
            tap_prev_reg <= tap;
            if ((phase_reg == tzpc_pkg::PH_Q2) || (phase_reg == tzpc_pkg::PH_Q4)) begin
                samp_reg <= cnt_src;
                samp_prev_reg <= samp_reg;
            end
        end
    end

    // advance decision
    always_comb begin
        if (sleep) begin
            inc = 1'b0;
        end else if (cfg_reg.src_ext) begin
            inc = rise(samp_prev_reg, samp_reg) &&
                  ((phase_reg == tzpc_pkg::PH_Q3) || (phase_reg == tzpc_pkg::PH_Q1));
        end else if (cfg_reg.bypass) begin
            inc = src_evt;
        end else begin
            inc = rise(tap_prev_reg, tap);
        end
    end

    // rollover from the top value
    assign ovf = inc && !cnt_wr && (count_reg == tzpc_pkg::COUNT_MAX);

    // timer_zero_count: write loads, event steps, sleep holds
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_reg <= tzpc_pkg::COUNT_RST;
        end else if (ce) begin
            if (cnt_wr) begin
                count_reg <= bus_req.wdata;
            end else if (inc) begin
                count_reg <= count_reg + tzpc_pkg::COUNT_ONE;
            end
        end
    end

    // configuration register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_reg.ps <= tzpc_pkg::PS_RST;
            cfg_reg.bypass <= tzpc_pkg::BYPASS_RST;
            cfg_reg.edge_fall <= tzpc_pkg::EDGE_RST;
            cfg_reg.src_ext <= tzpc_pkg::SRC_RST;
        end else if (ce && cfg_wr) begin
            cfg_reg.ps <= bus_req.wdata[tzpc_pkg::CFG_PS_LSB +: tzpc_pkg::CFG_PS_W];
            cfg_reg.bypass <= bus_req.wdata[tzpc_pkg::CFG_BYPASS_BIT];
            cfg_reg.edge_fall <= bus_req.wdata[tzpc_pkg::CFG_EDGE_BIT];
            cfg_reg.src_ext <= bus_req.wdata[tzpc_pkg::CFG_SRC_BIT];
        end
    end

    // overflow flag: set wins, cleared by writing one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else if (ce) begin
            if (ovf) begin
                flag_reg <= 1'b1;
            end else if (ic_wr && bus_req.wdata[tzpc_pkg::IC_FLAG_BIT]) begin
                flag_reg <= 1'b0;
            end
        end
    end

    // interrupt enable bit
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            en_reg <= 1'b0;
        end else if (ce && ic_wr) begin
            en_reg <= bus_req.wdata[tzpc_pkg::IC_EN_BIT];
        end
    end

    // level interrupt; frozen counter means no overflow can wake sleep
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= flag_reg && en_reg;
        end
    end

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = tzpc_pkg::DATA_ZERO;
        case (bus_req.addr)
            tzpc_pkg::ADDR_COUNT: rd_mux = count_reg;
            tzpc_pkg::ADDR_CONFIG: begin
                rd_mux[tzpc_pkg::CFG_PS_LSB +: tzpc_pkg::CFG_PS_W] = cfg_reg.ps;
                rd_mux[tzpc_pkg::CFG_BYPASS_BIT] = cfg_reg.bypass;
                rd_mux[tzpc_pkg::CFG_EDGE_BIT] = cfg_reg.edge_fall;
                rd_mux[tzpc_pkg::CFG_SRC_BIT] = cfg_reg.src_ext;
            end
            tzpc_pkg::ADDR_INTCTL: begin
                rd_mux[tzpc_pkg::IC_FLAG_BIT] = flag_reg;
                rd_mux[tzpc_pkg::IC_EN_BIT] = en_reg;
            end
            default: rd_mux = tzpc_pkg::DATA_ZERO;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= tzpc_pkg::DATA_ZERO;
        end else if (ce) begin
            rdata <= bus_req.rd ? rd_mux : tzpc_pkg::DATA_ZERO;
        end
    end

    // checks on the counting path
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // a write loads the count and clears the prescaler
    a_write_loads: assert property (ce && cnt_wr |=> count_reg == $past(bus_req.wdata))
        else $error("count not loaded by write");
    a_write_clears_presc: assert property (ce && cnt_wr |=> presc_reg == tzpc_pkg::PRESC_RST)
        else $error("prescaler not cleared by count write");

    // sleep keeps the count over two cycles
    a_sleep_holds: assert property (ce && sleep && !cnt_wr ##1 ce && sleep && !cnt_wr
        |=> count_reg == $past(count_reg, 2))
        else $error("count moved during sleep");

    // rollover wraps to zero and raises the flag
    a_ovf_flag_set: assert property (ce && ovf |=> flag_reg && count_reg == tzpc_pkg::COUNT_RST)
        else $error("overflow did not set flag");
    a_flag_no_enable: assert property (ce && ovf && !en_reg |=> flag_reg ##1 1'b1)
        else $error("flag depends on enable");

    // flag only falls on a software one-write
    a_flag_sticky: assert property (flag_reg && !(ce && ic_wr && bus_req.wdata[tzpc_pkg::IC_FLAG_BIT]) |=>
        flag_reg)
        else $error("flag cleared by hardware");
    a_flag_clear_cause: assert property ($fell(flag_reg) |-> $past(ic_wr && ce) &&
        $past(bus_req.wdata[tzpc_pkg::IC_FLAG_BIT]))
        else $error("flag cleared without software");

    // interrupt stays low one cycle after a flag with the enable clear
    a_irq_gate: assert property (ce && flag_reg && !en_reg |=> !irq)
        else $error("interrupt raised while disabled");

    // a step adds exactly one
    a_step_one: assert property (ce && inc && !cnt_wr |=> count_reg == $past(count_reg) + tzpc_pkg::COUNT_ONE)
        else $error("count step not one");

    // bypass in timer mode steps once per instruction cycle
    a_bypass_rate: assert property (ce && !sleep && cfg_reg.bypass && !cfg_reg.src_ext &&
        phase_reg == tzpc_pkg::PH_Q4 |-> inc)
        else $error("bypass did not step");

    // samples move only on Q2 or Q4
    a_sample_phase: assert property (ce && phase_reg != tzpc_pkg::PH_Q2 &&
        phase_reg != tzpc_pkg::PH_Q4 |=> $stable(samp_reg))
        else $error("sample taken off phase");

    // no advance of count or prescaler while asleep
    a_sleep_frozen: assert property (ce && sleep && !cnt_wr |=> $stable(count_reg) && $stable(presc_reg))
        else $error("advance during sleep");

    // a low enable freezes the counting state
    a_ce_freeze: assert property (!ce |=> $stable(count_reg) && $stable(presc_reg) &&
        $stable(phase_reg) && $stable(flag_reg))
        else $error("state moved with enable low");

    // the interrupt level is flag and enable, one cycle late
    a_irq_follows: assert property (ce |=> irq == $past(flag_reg && en_reg))
        else $error("interrupt not flag and enable");

    // the flag rises only on a rollover
    a_flag_rise: assert property ($rose(flag_reg) |-> $past(ce && ovf))
        else $error("flag set without overflow");

    // each accepted event steps the private prescaler by one
    a_presc_step: assert property (ce && src_evt && !sleep && !cnt_wr |=>
        presc_reg == $past(presc_reg) + tzpc_pkg::PRESC_ONE)
        else $error("prescaler step not one");

    // a configuration write lands in bypass and select
    a_cfg_write: assert property (ce && cfg_wr |=>
        cfg_reg.bypass == $past(bus_req.wdata[tzpc_pkg::CFG_BYPASS_BIT]) &&
        cfg_reg.ps == $past(bus_req.wdata[tzpc_pkg::CFG_PS_LSB +: tzpc_pkg::CFG_PS_W]))
        else $error("configuration not loaded");

    // read data carry the count, the flag, and zero elsewhere
    a_rdata_count: assert property (ce && bus_req.rd && bus_req.addr == tzpc_pkg::ADDR_COUNT |=>
        rdata == $past(count_reg))
        else $error("count read wrong");
    a_rdata_flag: assert property (ce && bus_req.rd && bus_req.addr == tzpc_pkg::ADDR_INTCTL |=>
        rdata[tzpc_pkg::IC_FLAG_BIT] == $past(flag_reg))
        else $error("flag read wrong");
    a_rdata_unmapped: assert property (ce && bus_req.rd && bus_req.addr > tzpc_pkg::ADDR_INTCTL |=>
        rdata == tzpc_pkg::DATA_ZERO)
        else $error("unmapped read not zero");

    // read data only after a read strobe
    a_rdata_once: assert property (!$past(bus_req.rd) && $past(ce) |-> rdata == tzpc_pkg::DATA_ZERO)
        else $error("read data outside its cycle");

    // main scenarios
    c_overflow: cover property (ce && ovf);
    c_ext_count: cover property (ce && inc && cfg_reg.src_ext);
    c_prescaled: cover property (ce && inc && !cfg_reg.bypass && cfg_reg.ps == 3'h7);
    c_irq: cover property (irq);
    c_sleep_event: cover property (ce && sleep && src_evt);

endmodule

// ---- tzpc_pkg.sv ----
// shared constants and types for the prescaled timer-zero counter
package tzpc_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] ADDR_COUNT = 8'h00;   // timer_zero_count
    localparam logic [7:0] ADDR_CONFIG = 8'h01;  // source, edge, bypass, prescale
    localparam logic [7:0] ADDR_INTCTL = 8'h02;  // interrupt_control

    // field positions in the configuration register
    localparam int CFG_PS_LSB = 0;
    localparam int CFG_PS_W = 3;
    localparam int CFG_BYPASS_BIT = 3;
    localparam int CFG_EDGE_BIT = 4;
    localparam int CFG_SRC_BIT = 5;

    // field positions in interrupt_control
    localparam int IC_FLAG_BIT = 2;
    localparam int IC_EN_BIT = 5;

    // counter and data constants
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] PRESC_RST = 8'h00;
    localparam logic [7:0] PRESC_ONE = 8'h01;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // configuration reset values
    localparam logic [2:0] PS_RST = 3'h7;
    localparam logic BYPASS_RST = 1'b1;
    localparam logic EDGE_RST = 1'b1;
    localparam logic SRC_RST = 1'b1;

    // quarter phases of one instruction cycle, one mclk each
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } tzpc_phase_t;

    // counting configuration
    typedef struct packed {
        logic src_ext;
        logic edge_fall;
        logic bypass;
        logic [2:0] ps;
    } tzpc_cfg_t;

    // one register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tzpc_bus_t;

endpackage

// ---- tzpc_sync.sv ----
`timescale 1ns/1ps
// three-flop pin synchroniser; the level changes once the last two stages agree
module tzpc_sync (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // asynchronous pin and its clean level
    input wire logic pin,
    output logic level
);

    logic s1_reg;  // first stage, read only by the second
    logic s2_reg;  // second stage
    logic s3_reg;  // third stage

    // shift the pin through three flops
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else if (ce) begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // accept a new level only when stages two and three agree
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (ce && (s2_reg == s3_reg)) begin
            level <= s3_reg;
        end
    end

endmodule

// ---- tzpc_ext_src.sv ----
`timescale 1ns/1ps
// behavioural pulse source on the external count pin; idles low between bursts
module tzpc_ext_src (
    // pulse output toward the counter pin
    output logic pin
);
    // pin starts low and stays still outside a burst
    initial begin
        pin = 1'b0;
    end

    // n pulses, each level held at least two instruction cycles, slow or prompt at random
    task automatic pulses(input int n);
        repeat (n) begin
            #(34 + $urandom_range(30, 0)) pin = 1'b1;
            #(34 + $urandom_range(30, 0)) pin = 1'b0;
        end
        #40;
    endtask
endmodule

// ---- test_timer_zero_prescaled_counter.sv ----
`timescale 1ns/1ps
// self-checking bench for the prescaled timer-zero counter
module test_timer_zero_prescaled_counter;
    logic mclk; // 250 MHz clock
    logic rst_n; // synchronous reset, active low
    logic ce; // clock enable, high except for the 40-cycle freeze window in the bypass test
    tzpc_pkg::tzpc_bus_t bus_req; // register port request
    logic [7:0] rdata; // read data, one cycle after the strobe
    logic external_count_input; // pin driven by the pulse source
    logic sleep; // processor sleep level
    logic irq; // interrupt level
    logic rd_q; // a read was taken in the previous cycle
    logic [7:0] exp_q[$]; // expected read data, oldest first
    logic [7:0] x; // random start count
    int m; // random window length in instruction cycles
    int failures; // mismatches seen
    int checks_done; // comparisons made

    // device under test and its far-side pulse source
    tzpc_top u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .rdata(rdata),
        .external_count_input(external_count_input), .sleep(sleep), .irq(irq));
    tzpc_ext_src u_src (.pin(external_count_input));

    // free-running clock
    initial begin
        mclk = 1'b0;
    end
    always #2 mclk = ~mclk;

    // single comparison point
    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    // one strobe cycle, then one idle cycle so no signal is assigned twice in a step
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
    endtask

    // register write
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 1'b1);
    endtask

    // register read; the expectation is noted for the watcher
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        acc(a, 8'h00, 1'b0);
    endtask

    // configuration write, then time for the synchroniser to settle
    task automatic cfg(input logic [7:0] v);
        reg_wr(tzpc_pkg::ADDR_CONFIG, v);
        repeat (12) @(posedge mclk);
    endtask

    // awake for exactly n clock edges, asleep again afterwards
    task automatic run(input int n);
        sleep <= 1'b0;
        repeat (n) @(posedge mclk);
        sleep <= 1'b1;
    endtask

    // counter mode: n pin pulses must add inc to a random start count
    task automatic pulse_chk(input logic [7:0] v, input int n, input logic [7:0] inc, input logic sl);
        sleep <= sl;
        cfg(v);
        x = 8'($urandom);
        reg_wr(tzpc_pkg::ADDR_COUNT, x);
        u_src.pulses(n);
        repeat (16) @(posedge mclk);
        reg_rd(tzpc_pkg::ADDR_COUNT, x + inc);
    endtask

    // irq level, looked at mid-cycle then realigned to the rising edge
    task automatic irq_chk(input logic want);
        @(negedge mclk);
        check({7'h00, irq}, {7'h00, want}, "irq level");
        @(posedge mclk);
    endtask

    // end-of-test line
    task automatic done_test(input string name);
        $display("test %s finished, %0d mismatches so far", name, failures);
    endtask

    // verdict and end of run
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watcher: compares read data in the cycle after each read strobe
    always @(posedge mclk) begin
        rd_q <= bus_req.rd & rst_n;
        if (rd_q === 1'b1) begin
            check(rdata, exp_q.pop_front(), "read data");
        end
    end

    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge mclk);
        failures++;
        give_verdict();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        sleep = 1'b1;
        bus_req = '0;
        rd_q = 1'b0;
        failures = 0;
        checks_done = 0;
        void'($urandom(32'hA6751424));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        // reset values and an unmapped place
        reg_wr(8'h07, 8'hFF);
        reg_rd(tzpc_pkg::ADDR_COUNT, 8'h00);
        reg_rd(tzpc_pkg::ADDR_CONFIG, 8'h3F);
        reg_rd(tzpc_pkg::ADDR_INTCTL, 8'h00);
        reg_rd(8'h03, 8'h00);
        done_test("reset");
        // bypassed prescaler: one step per instruction cycle, frozen while asleep
        cfg(8'h08);
        x = 8'($urandom);
        m = $urandom_range(20, 1);
        reg_wr(tzpc_pkg::ADDR_COUNT, x);
        run(4 * m);
        reg_rd(tzpc_pkg::ADDR_COUNT, x + 8'(m));
        repeat (40) @(posedge mclk);
        reg_rd(tzpc_pkg::ADDR_COUNT, x + 8'(m));
        // awake but with the enable low: nothing may move
        sleep <= 1'b0;
        ce <= 1'b0;
        repeat (40) @(posedge mclk);
        ce <= 1'b1;
        sleep <= 1'b1;
        reg_rd(tzpc_pkg::ADDR_COUNT, x + 8'(m));
        done_test("bypass");
        // every prescale code: two steps in a window of two prescaler periods
        for (int ps = 0; ps < 8; ps++) begin
            cfg(8'(ps));
            x = 8'($urandom);
            reg_wr(tzpc_pkg::ADDR_COUNT, x);
            run(8 << (ps + 1));
            reg_rd(tzpc_pkg::ADDR_COUNT, x + 8'h02);
        end
        done_test("prescale");
        // a count write restarts the prescaler from zero
        cfg(8'h02);
        for (int pre = 3; pre < 16; pre += 8) begin
            reg_wr(tzpc_pkg::ADDR_COUNT, 8'h00);
            run(4 * pre);
            x = 8'($urandom);
            reg_wr(tzpc_pkg::ADDR_COUNT, x);
            run(12);
            reg_rd(tzpc_pkg::ADDR_COUNT, x);
        end
        done_test("prescaler clear");
        // overflow, sticky flag, enable gating and write-one clear
        cfg(8'h08);
        reg_wr(tzpc_pkg::ADDR_INTCTL, 8'h04);
        reg_wr(tzpc_pkg::ADDR_COUNT, 8'hFE);
        run(8);
        reg_rd(tzpc_pkg::ADDR_COUNT, 8'h00);
        reg_rd(tzpc_pkg::ADDR_INTCTL, 8'h04);
        irq_chk(1'b0);
        run(12);
        reg_rd(tzpc_pkg::ADDR_INTCTL, 8'h04);
        reg_wr(tzpc_pkg::ADDR_INTCTL, 8'h20);
        @(posedge mclk);
        irq_chk(1'b1);
        reg_wr(tzpc_pkg::ADDR_INTCTL, 8'h20);
        reg_rd(tzpc_pkg::ADDR_INTCTL, 8'h24);
        reg_wr(tzpc_pkg::ADDR_INTCTL, 8'h24);
        reg_rd(tzpc_pkg::ADDR_INTCTL, 8'h20);
        irq_chk(1'b0);
        done_test("overflow");
        // counter mode: rising and falling edges, prescaled, and asleep
        pulse_chk(8'h28, 5, 8'h05, 1'b0);
        pulse_chk(8'h38, 3, 8'h03, 1'b0);
        pulse_chk(8'h30, 4, 8'h02, 1'b0);
        pulse_chk(8'h38, 3, 8'h00, 1'b1);
        done_test("counter");
        give_verdict();
    end
endmodule
